// >>> hdl/slh_consts.svh
`ifndef SLH_CONSTS_SVH
`define SLH_CONSTS_SVH
// Wake-up counter: 13 stages, mid-count check and full wrap
`define SLH_CNT_W        13
`define SLH_MID_COUNT    13'h1000
`define SLH_PSTOP_FAST   13'h0010
`endif

// >>> hdl/slh_pkg.sv
package slh_pkg;
    typedef enum {
        ST_RUN,
        ST_STOP,
        ST_WAKE_WAIT,
        ST_LIMP
    } slh_state_t;
    typedef struct packed {
        logic limp_home_disable;
        logic clock_monitor_enable;
        logic forced_clock_monitor_enable;
        logic wake_delay_select;
        logic pseudo_stop_enable;
        logic limp_home_irq_enable;
    } slh_cfg_t;
    typedef struct packed {
        logic pll_bus_clock_select;
        logic module_clock_select;
    } slh_sel_t;
endpackage

// >>> hdl/slh_counter.sv
`timescale 1ns/1ps
`include "slh_consts.svh"
module slh_counter (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    // Control
    input  wire logic                  tick_i,
    input  wire logic                  clear_i,
    // Status
    output logic                       mid_o
);
    logic [`SLH_CNT_W-1:0] count_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= '0;
        end else if (clear_i) begin
            count_r <= '0;
        end else if (tick_i) begin
            count_r <= count_r + 13'h0001;
        end
    end

    // Pulses once per wrap, as the count first passes its midpoint
    assign mid_o = tick_i && !clear_i &&
                   (count_r == (`SLH_MID_COUNT - 13'h0001));
endmodule // slh_counter

// >>> hdl/slh_sequencer.sv
`timescale 1ns/1ps
`include "slh_consts.svh"
//Contract
// - Delay-select one holds wake for 4096 counts
// - Counter steps on watchdog module clock ticks, on VCO ticks in limp-home
// - Reset, interrupts, key or CAN wake end STOP
// - No limp, monitor off: exit on external clock
// - No limp, monitor on: STOP means monitor reset
// - Limp enabled masks monitor, exits into limp-home
// - After 4096, good clock leaves limp-home
// - No clock at 4096: limp status, irq flag set
// - In limp-home, check monitor at every midpoint
// - Clock found: leave limp, clear status, set flag
// - Leaving limp restores saved bus/module selects
// - Limp enabled, no delay: release immediately
// - Good clock, no delay: never set limp status
// - Pseudo-stop bit turns STOP into pseudo-STOP
// - Pseudo-STOP wakes and delays like STOP
// - Pseudo exit with delay enters limp, forces selects
// - Pseudo exit limp, no delay: immediate release
// - Pseudo, no limp, delay: 4096 on external clock
// - Pseudo, no limp, no delay: 16 cycles
// - Limp-home: VCO clocks, monitor forced enabled
// - Irq flag clears only on write of one
module slh_sequencer (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Configuration
    input  slh_pkg::slh_cfg_t      cfg_i,
    input  slh_pkg::slh_sel_t      sel_i,
    // Events and clock ticks
    input  wire logic              stop_exec_i,
    input  wire logic              wake_irq_i,
    input  wire logic              wake_nonmaskable_ext_interrupt_pin_i,
    input  wire logic              wake_key_j_i,
    input  wire logic              wake_key_h_i,
    input  wire logic              wake_can_i,
    input  wire logic              ext_reset_i,
    input  wire logic              module_tick_i,
    input  wire logic              vco_tick_i,
    input  wire logic              ext_clock_ok_i,
    input  wire logic              flag_clear_i,
    // Status and clock control
    output logic                   stopped_o,
    output logic                   pseudo_stop_o,
    output logic                   cpu_run_o,
    output logic                   monitor_reset_o,
    output logic                   limp_home_status_o,
    output logic                   limp_home_irq_flag_o,
    output logic                   irq_o,
    output logic                   monitor_active_o,
    output logic                   vco_as_clock_o,
    output slh_pkg::slh_sel_t      sel_o
);
    slh_pkg::slh_state_t state_r;
    slh_pkg::slh_sel_t   saved_r;
    logic                pseudo_r;
    logic                ext_s1_r;
    logic                ext_ok_r;
    logic [5:0]          wake_s1_r;
    logic [5:0]          wake_s2_r;
    logic                mid;
    logic                tick;
    logic                wake;
    logic                cnt_clr;
    logic                mon_en;
    logic [4:0]          fast_cnt_r;
    logic                set_flag;
    logic                limp_r;
    logic                go_limp;
    logic                leave_limp;

    // Monitor status crosses from the oscillator domain
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ext_s1_r <= 1'h0;
            ext_ok_r <= 1'h0;
        end else begin
            ext_s1_r <= ext_clock_ok_i;
            ext_ok_r <= ext_s1_r;
        end
    end

    assign mon_en = cfg_i.clock_monitor_enable |
                    cfg_i.forced_clock_monitor_enable;
    // Wake pins are asynchronous to the sequencer clock
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wake_s1_r <= 6'h00;
            wake_s2_r <= 6'h00;
        end else begin
            wake_s1_r <= {ext_reset_i, wake_can_i, wake_key_h_i,
                          wake_key_j_i, wake_nonmaskable_ext_interrupt_pin_i, wake_irq_i};
            wake_s2_r <= wake_s1_r;
        end
    end

    assign wake = |wake_s2_r;
    // Limp-home counts on VCO, otherwise on module clock ticks
    assign tick = limp_r ? vco_tick_i : module_tick_i;
    assign cnt_clr = (state_r == slh_pkg::ST_STOP);

    slh_counter u_counter (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .clear_i (cnt_clr),
        .mid_o   (mid)
    );

    // Limp entry when waking with limp enabled and either delay selected or no good clock
    assign go_limp = (state_r == slh_pkg::ST_STOP) && wake &&
                     !cfg_i.limp_home_disable &&
                     (cfg_i.wake_delay_select || !ext_ok_r);
    assign leave_limp = limp_r && mid && ext_ok_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= slh_pkg::ST_RUN;
            pseudo_r   <= 1'h0;
            fast_cnt_r <= 5'h00;
        end else begin
            case (state_r)
                slh_pkg::ST_RUN: begin
                    if (stop_exec_i && !(cfg_i.limp_home_disable &&
                                         mon_en)) begin
                        state_r  <= slh_pkg::ST_STOP;
                        pseudo_r <= cfg_i.pseudo_stop_enable;
                    end
                end
                slh_pkg::ST_STOP: begin
                    fast_cnt_r <= 5'h00;
                    if (wake) begin
                        if (cfg_i.wake_delay_select ||
                            (pseudo_r && cfg_i.limp_home_disable)) begin
                            state_r <= slh_pkg::ST_WAKE_WAIT;
                        end else begin
                            state_r <= slh_pkg::ST_RUN;
                        end
                    end
                end
                slh_pkg::ST_WAKE_WAIT: begin
                    if (cfg_i.wake_delay_select) begin
                        if (mid) begin
                            state_r <= slh_pkg::ST_RUN;
                        end
                    end else if (module_tick_i) begin
                        fast_cnt_r <= fast_cnt_r + 5'h01;
                        if (fast_cnt_r == 5'(`SLH_PSTOP_FAST - 13'h0001)) begin
                            state_r <= slh_pkg::ST_RUN;
                        end
                    end
                end
                default: state_r <= slh_pkg::ST_RUN;
            endcase
        end
    end

    // Limp-home mode tracking and first-check decision
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            limp_r <= 1'h0;
        end else if (go_limp) begin
            limp_r <= 1'h1;
        end else if (limp_r && mid && ext_ok_r) begin
            limp_r <= 1'h0;
        end
    end

    // Status flag is raised when limp is still on in RUN or at a midpoint check
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            limp_home_status_o <= 1'h0;
        end else if (leave_limp) begin
            limp_home_status_o <= 1'h0;
        end else if (limp_r && (state_r != slh_pkg::ST_STOP) &&
                     ((state_r == slh_pkg::ST_RUN) || mid) &&
                     !limp_home_status_o) begin
            limp_home_status_o <= 1'h1;
        end
    end

    assign set_flag = leave_limp && limp_home_status_o ||
                      (limp_r && !limp_home_status_o &&
                       (state_r != slh_pkg::ST_STOP) &&
                       ((state_r == slh_pkg::ST_RUN) || mid) &&
                       !(mid && ext_ok_r));

    // Set wins over the software clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            limp_home_irq_flag_o <= 1'h0;
        end else if (set_flag) begin
            limp_home_irq_flag_o <= 1'h1;
        end else if (flag_clear_i) begin
            limp_home_irq_flag_o <= 1'h0;
        end
    end

    // Selects are saved on STOP and forced while limping
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            saved_r <= '0;
            sel_o   <= '0;
        end else begin
            if (stop_exec_i && state_r == slh_pkg::ST_RUN) begin
                saved_r <= sel_i;
            end
            if (go_limp || limp_r && !leave_limp) begin
                sel_o <= 2'h2;
            end else if (leave_limp) begin
                sel_o <= saved_r;
            end else begin
                sel_o <= sel_i;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stopped_o        <= 1'h0;
            pseudo_stop_o    <= 1'h0;
            cpu_run_o        <= 1'h1;
            monitor_reset_o  <= 1'h0;
            irq_o            <= 1'h0;
            monitor_active_o <= 1'h0;
            vco_as_clock_o   <= 1'h0;
        end else begin
            stopped_o       <= (state_r == slh_pkg::ST_STOP);
            pseudo_stop_o   <= (state_r == slh_pkg::ST_STOP) && pseudo_r;
            cpu_run_o       <= (state_r == slh_pkg::ST_RUN);
            monitor_reset_o <= (state_r == slh_pkg::ST_RUN) && stop_exec_i &&
                               cfg_i.limp_home_disable && mon_en;
            irq_o           <= limp_home_irq_flag_o &&
                               cfg_i.limp_home_irq_enable;
            // Monitor masked in STOP, forced on in limp-home
            monitor_active_o <= limp_r ||
                                (mon_en &&
                                 state_r != slh_pkg::ST_STOP);
            vco_as_clock_o  <= limp_r;
        end
    end

    a_monitor_reset: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == slh_pkg::ST_RUN && stop_exec_i &&
         cfg_i.limp_home_disable && mon_en) |=> monitor_reset_o)
        else $error("monitor reset missing");

    a_flag_sticky: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (limp_home_irq_flag_o && !flag_clear_i) |=> limp_home_irq_flag_o)
        else $error("irq flag dropped");

    a_limp_vco: assert property (
        @(posedge clock_i) disable iff (rst_i)
        limp_r |=> vco_as_clock_o)
        else $error("vco not selected in limp");

    a_stop_stays: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == slh_pkg::ST_STOP && !wake) |=>
        state_r == slh_pkg::ST_STOP)
        else $error("stop left without wake");

    a_limp_select: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (limp_r && !leave_limp) |=> (sel_o == 2'h2))
        else $error("selects not forced in limp");

    a_leave_flags: assert property (
        @(posedge clock_i) disable iff (rst_i)
        leave_limp |=> (!limp_home_status_o && limp_home_irq_flag_o))
        else $error("limp exit flags wrong");

    a_irq_request: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (limp_home_irq_flag_o && cfg_i.limp_home_irq_enable) |=> irq_o)
        else $error("limp irq not requested");

    a_fast_no_limp: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (state_r == slh_pkg::ST_STOP && wake && !limp_r &&
         !cfg_i.wake_delay_select && ext_ok_r) |=> !limp_r)
        else $error("limp entered with good clock");
endmodule // slh_sequencer

// >>> tb/slh_osc_model.sv
`timescale 1ns/1ps
module slh_osc_model (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Oscillator activity
    input  wire logic osc_on_i,
    // Clock enables and monitor
    output logic      module_tick_o,
    output logic      vco_tick_o,
    output logic      ext_clock_ok_o
);
    // Half rate so that the prescaler shows in every module-clock delay
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) module_tick_o <= 1'h0;
        else module_tick_o <= osc_on_i & ~module_tick_o;
    end
    // VCO at its minimum rate runs free
    assign vco_tick_o     = 1'h1;
    assign ext_clock_ok_o = osc_on_i;
endmodule // slh_osc_model

// >>> tb/stop_exit_limp_home_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module stop_exit_limp_home_sequencer_tb_top;
    logic               clock_i, rst_i, stop_exec, flag_clr, osc_on;
    logic [5:0]         wk;
    slh_pkg::slh_cfg_t  cfg;
    slh_pkg::slh_sel_t  sel, sel_o;
    logic               mtick, vtick, ok, stopped, pstop, cpu_run, mon_rst;
    logic               lh_stat, lh_flag, irq, mon_act, vco_clk;
    int                 err_count, num_checks, cyc;
    slh_osc_model i_slh_osc_model (.clock_i(clock_i), .rst_i(rst_i),
        .osc_on_i(osc_on), .module_tick_o(mtick), .vco_tick_o(vtick),
        .ext_clock_ok_o(ok));
    slh_sequencer i_slh_sequencer (.clock_i(clock_i), .rst_i(rst_i),
        .cfg_i(cfg), .sel_i(sel), .stop_exec_i(stop_exec),
        .wake_irq_i(wk[0]), .wake_nonmaskable_ext_interrupt_pin_i(wk[1]), .wake_key_j_i(wk[2]),
        .wake_key_h_i(wk[3]), .wake_can_i(wk[4]), .ext_reset_i(wk[5]),
        .module_tick_i(mtick), .vco_tick_i(vtick), .ext_clock_ok_i(ok),
        .flag_clear_i(flag_clr), .stopped_o(stopped), .pseudo_stop_o(pstop),
        .cpu_run_o(cpu_run), .monitor_reset_o(mon_rst),
        .limp_home_status_o(lh_stat), .limp_home_irq_flag_o(lh_flag),
        .irq_o(irq), .monitor_active_o(mon_act), .vco_as_clock_o(vco_clk),
        .sel_o(sel_o));
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic do_reset();
        @(posedge clock_i) rst_i <= 1'h1;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic go_stop();
        @(posedge clock_i) stop_exec <= 1'h1;
        @(posedge clock_i) stop_exec <= 1'h0;
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    task automatic wake(input int b);
        @(posedge clock_i) wk <= 6'h01 << b;
        @(posedge clock_i) wk <= '0;
    endtask
    task automatic wait_run(input int lo, input int hi, input string nm);
        int n;
        n = 0;
        while (cpu_run !== 1'h1 && n < hi) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        `CHK({nm, " early"}, 1'h1, n >= lo)
        `CHK({nm, " run"}, 1'h1, cpu_run)
    endtask
    task automatic t_delay();
        @(posedge clock_i) cfg <= 6'h24;
        go_stop();
        `CHK("stopped", 1'h1, stopped)
        wake(0);
        wait_run(8000, 8400, "delay");
        `CHK("no limp", 1'h0, lh_stat)
    endtask
    task automatic t_monitor();
        logic seen;
        for (int i = 0; i < 2; i++) begin
            do_reset();
            seen = 1'h0;
            cfg <= (i == 0) ? 6'h30 : 6'h28;
            @(posedge clock_i) stop_exec <= 1'h1;
            @(posedge clock_i) stop_exec <= 1'h0;
            repeat (4) begin
                #1;
                seen |= mon_rst;
                @(posedge clock_i);
            end
            #1;
            `CHK("mon reset", 1'h1, seen)
            `CHK("mon no stop", 1'h0, stopped)
        end
        do_reset();
    endtask
    task automatic t_limp();
        int n;
        @(posedge clock_i) cfg <= 6'h15;
        sel <= 2'h3;
        osc_on <= 1'h0;
        go_stop();
        wake(2);
        wait_run(4000, 4400, "limp");
        `CHK("lh stat", 1'h1, lh_stat)
        `CHK("lh flag", 1'h1, lh_flag)
        `CHK("vco clk", 1'h1, vco_clk)
        `CHK("mon act", 1'h1, mon_act)
        `CHK("forced sel", 2'h2, sel_o)
        @(posedge clock_i) flag_clr <= 1'h1;
        @(posedge clock_i) flag_clr <= 1'h0;
        repeat (2) @(posedge clock_i);
        #1;
        `CHK("flag clr", 1'h0, lh_flag)
        @(posedge clock_i) osc_on <= 1'h1;
        sel <= 2'h1;
        n = 0;
        while (lh_stat !== 1'h0 && n < 8500) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        `CHK("lh exit", 1'h0, lh_stat)
        `CHK("exit flag", 1'h1, lh_flag)
        `CHK("restored", 2'h3, sel_o)
        @(posedge clock_i);
        #1;
        `CHK("exit irq", 1'h1, irq)
        `CHK("ext clk", 1'h0, vco_clk)
        `CHK("sw sel", 2'h1, sel_o)
    endtask
    task automatic t_pseudo();
        @(posedge clock_i) cfg <= 6'h06;
        go_stop();
        `CHK("pseudo", 1'h1, pstop)
        wake(3);
        repeat (4) @(posedge clock_i);
        #1;
        `CHK("pseudo sel", 2'h2, sel_o)
        wait_run(3990, 4400, "ps limp");
        `CHK("ps ext", 1'h0, lh_stat)
        @(posedge clock_i) cfg <= 6'h22;
        go_stop();
        wake(1);
        wait_run(20, 50, "ps16");
        @(posedge clock_i) cfg <= 6'h26;
        go_stop();
        wake(5);
        wait_run(8000, 8400, "ps4096");
    endtask
    task automatic t_fast();
        int n;
        @(posedge clock_i) cfg <= 6'h00;
        go_stop();
        wake(4);
        wait_run(0, 6, "fast");
        repeat (20) @(posedge clock_i);
        #1;
        `CHK("fast stat", 1'h0, lh_stat)
        @(posedge clock_i) osc_on <= 1'h0;
        go_stop();
        wake(0);
        wait_run(0, 6, "fast limp");
        `CHK("fast lh", 1'h1, lh_stat)
        `CHK("fast vco", 1'h1, vco_clk)
        @(posedge clock_i) osc_on <= 1'h1;
        n = 0;
        while (lh_stat !== 1'h0 && n < 8500) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        `CHK("fast exit", 1'h0, lh_stat)
        @(posedge clock_i) cfg <= 6'h20;
        for (int b = 0; b < 6; b++) begin
            go_stop();
            wake(b);
            wait_run(0, 40, "source");
        end
    endtask
    initial begin
        {rst_i, stop_exec, flag_clr, wk, err_count, num_checks, cyc} = '0;
        rst_i = 1'h1;
        cfg = 6'h20;
        sel = 2'h0;
        osc_on = 1'h1;
        do_reset();
        t_delay();
        t_monitor();
        t_limp();
        t_pseudo();
        t_fast();
        print_verdict();
    end
endmodule // stop_exit_limp_home_sequencer_tb_top
